// ### event_flag_pkg.sv
// constants shared by the global event flag registers
// assumes nothing beyond a SystemVerilog compiler
package event_flag_pkg;

    // ************************************************************
    // register offsets and reset values
    // ************************************************************
    localparam logic [7:0] GLOBAL_EVENT_FLAGS_A_OFFSET = 8'h00;
    localparam logic [7:0] GLOBAL_EVENT_FLAGS_B_OFFSET = 8'h04;
    localparam logic [7:0] GLOBAL_EVENT_FLAGS_A_RESET  = 8'h00;
    localparam logic [7:0] GLOBAL_EVENT_FLAGS_B_RESET  = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE         = 8'h00;
    localparam logic [7:0] READ_DATA_RESET             = 8'h00;

    // ************************************************************
    // field positions, first register
    // ************************************************************
    localparam int DROPOUT_RISE_BIT           = 7;
    localparam int THERMAL_ALARM_HI_RISE_BIT  = 5;
    localparam int THERMAL_ALARM_LO_RISE_BIT  = 4;
    localparam int ENABLE_PIN_RISE_BIT        = 3;
    localparam int ENABLE_PIN_FALL_BIT        = 2;
    localparam int GP_PIN0_RISE_BIT           = 1;
    localparam int GP_PIN0_FALL_BIT           = 0;

    // ************************************************************
    // field positions, second register
    // ************************************************************
    localparam int LINEAR_REG_FAULT_BIT       = 5;
    localparam int BUCK_BOOST_TIMEOUT_BIT     = 4;
    localparam int GP_PIN1_RISE_BIT           = 1;
    localparam int GP_PIN1_FALL_BIT           = 0;

    // ************************************************************
    // synchronised level sources, index into the level vector
    // ************************************************************
    localparam int SRC_DROPOUT                = 0;
    localparam int SRC_THERMAL_HI             = 1;
    localparam int SRC_THERMAL_LO             = 2;
    localparam int SRC_LINEAR_FAULT           = 3;
    localparam int SRC_GP_PIN0                = 4;
    localparam int SRC_GP_PIN1                = 5;
    localparam int SRC_COUNT                  = 6;

    // ************************************************************
    // timing
    // ************************************************************
    // cycles after reset before edges count: two sync stages plus one history stage
    localparam logic [1:0] ARM_CYCLES         = 2'h3;

endpackage

// ### global_event_flag_registers.sv
// global event flag registers: two read-to-clear flag bytes fed by edge detectors and the buck-boost timeout level
// assumes the register port is driven from logic on MCLK_IN and the
// enable level arrives already debounced on the same clock
`timescale 1ns/10ps

// Function
// [RL1] bit 7 of the first register sets when the dropout detector reports dropout and holds until read.
// [RL2] bit 5 of the first register sets when the junction temperature rises past the high alarm and holds.
// [RL3] bit 4 of the first register sets when the junction temperature rises past the low alarm and holds.
// [RL4] bit 3 of the first register sets on each rising edge of the enable input and holds until read.
// [RL5] bit 2 of the first register sets on each falling edge of the enable input and holds until read.
// [RL6] bit 1 of the first register sets on a rising edge of general-purpose pin 0 and holds until read.
// [RL7] bit 0 of the first register sets on a falling edge of general-purpose pin 0 and holds until read.
// [RL8] bit 5 of the second register sets when the linear regulator leaves regulation and holds until read.
// [RL9] bit 4 of the second register sets on a buck-boost timeout and holds until read.
// [RL10] bit 1 of the second register sets on a rising edge of general-purpose pin 1 and holds until read.
// [RL11] bit 0 of the second register sets on a falling edge of general-purpose pin 1 and holds until read.
// [RL12] unused bits are written as zero by the host and may read as anything; here they read zero.
// [RL13] all flags reset to zero, and a read returns the flags then clears the whole register read.
// [RL14] pin edge flags come only from a pin configured as an input, never from an output; here an edge while output counts if the next two cycles are input.
// [RL15] the enable input is active low and its edge flags are taken from the debounced level.
// [RL16] an event landing in the same cycle as a read-clear of its register leaves the flag set.
module global_event_flag_registers
    import event_flag_pkg::*;
(
    // clock and reset
    input  wire logic       MCLK_IN,
    input  wire logic       NRST_IN,
    // analog detector levels, asynchronous
    input  wire logic       DROPOUT_DETECT_IN,
    input  wire logic       THERMAL_THRESHOLD_HI_IN,
    input  wire logic       THERMAL_THRESHOLD_LO_IN,
    input  wire logic       LINEAR_REG_FAULT_IN,
    // enable pin, debounced level on this clock, low means active
    input  wire logic       ENABLE_INPUT_PIN_N_IN,
    // general-purpose pins, asynchronous, and their direction (1 = input)
    input  wire logic       GP_INPUT0_IN,
    input  wire logic       GP_INPUT1_IN,
    input  wire logic       GP_PIN0_IS_INPUT_IN,
    input  wire logic       GP_PIN1_IS_INPUT_IN,
    // buck-boost timeout, one-cycle pulse on this clock
    input  wire logic       BUCK_BOOST_TIMEOUT_IN,
    // register read port
    input  wire logic       REG_RD_IN,
    input  wire logic [7:0] REG_ADDR_IN,
    output logic      [7:0] REG_RDATA_OUT,
    output logic            REG_RVALID_OUT
);

    // ************************************************************
    // synchronisers and edge history
    // ************************************************************
    logic [SRC_COUNT-1:0] raw_level;
    logic [SRC_COUNT-1:0] sync_stage1;
    logic [SRC_COUNT-1:0] sync_level;
    logic [SRC_COUNT-1:0] prev_level;
    logic [SRC_COUNT-1:0] rise;
    logic [SRC_COUNT-1:0] fall;
    logic                 prev_enable_n;
    logic                 prev_gp0_is_input;
    logic                 prev_gp1_is_input;
    logic [1:0]           arm_count;
    logic                 armed;

    assign raw_level[SRC_DROPOUT]      = DROPOUT_DETECT_IN;
    assign raw_level[SRC_THERMAL_HI]   = THERMAL_THRESHOLD_HI_IN;
    assign raw_level[SRC_THERMAL_LO]   = THERMAL_THRESHOLD_LO_IN;
    assign raw_level[SRC_LINEAR_FAULT] = LINEAR_REG_FAULT_IN;
    assign raw_level[SRC_GP_PIN0]      = GP_INPUT0_IN;
    assign raw_level[SRC_GP_PIN1]      = GP_INPUT1_IN;

    genvar i;
    generate
        for (i = 0; i < SRC_COUNT; i++) begin : g_src
            always_ff @(posedge MCLK_IN) begin
                if (!NRST_IN) begin
                    sync_stage1[i] <= 1'b0;
                    sync_level[i]  <= 1'b0;
                    prev_level[i]  <= 1'b0;
                end else begin
                    sync_stage1[i] <= raw_level[i];
                    sync_level[i]  <= sync_stage1[i];
                    prev_level[i]  <= sync_level[i];
                end
            end
            // edges are ignored until the pipeline holds real samples, so reset never fakes one
            assign rise[i] = armed & sync_level[i] & ~prev_level[i];
            assign fall[i] = armed & ~sync_level[i] & prev_level[i];
        end
    endgenerate

    // ************************************************************
    // arm counter
    // ************************************************************
    // edges are held off until every stage of the pipeline holds a real sample
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            arm_count <= 2'h0;
        end else if (arm_count != ARM_CYCLES) begin
            arm_count <= arm_count + 2'h1;
        end
    end

    assign armed = (arm_count == ARM_CYCLES);

    // ************************************************************
    // same-clock history
    // ************************************************************
    // enable resets to its idle high level so no false edge waits behind the arm delay
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            prev_enable_n     <= 1'b1;
            prev_gp0_is_input <= 1'b0;
            prev_gp1_is_input <= 1'b0;
        end else begin
            prev_enable_n     <= ENABLE_INPUT_PIN_N_IN;
            prev_gp0_is_input <= GP_PIN0_IS_INPUT_IN;
            prev_gp1_is_input <= GP_PIN1_IS_INPUT_IN;
        end
    end

    // ************************************************************
    // event decode
    // ************************************************************
    logic enable_rise;
    logic enable_fall;
    logic gp0_counts;
    logic gp1_counts;

    // pin level high means inactive, so a rise is the pin being released
    assign enable_rise = armed & ENABLE_INPUT_PIN_N_IN & ~prev_enable_n;   // [RL15]
    assign enable_fall = armed & ~ENABLE_INPUT_PIN_N_IN & prev_enable_n;   // [RL15]
    // a direction change must not look like a pin edge, so input must hold two cycles
    assign gp0_counts  = GP_PIN0_IS_INPUT_IN & prev_gp0_is_input;         // [RL14]
    assign gp1_counts  = GP_PIN1_IS_INPUT_IN & prev_gp1_is_input;         // [RL14]

    // ************************************************************
    // per-flag events
    // ************************************************************
    logic dropout_rise_event;
    logic thermal_hi_rise_event;
    logic thermal_lo_rise_event;
    logic enable_rise_event;
    logic enable_fall_event;
    logic gp_pin0_rise_event;
    logic gp_pin0_fall_event;
    logic linear_fault_event;
    logic timeout_event;
    logic gp_pin1_rise_event;
    logic gp_pin1_fall_event;

    // detector flags fire on the edge into the bad state, not while it lasts
    assign dropout_rise_event    = rise[SRC_DROPOUT];                 // [RL1]
    assign thermal_hi_rise_event = rise[SRC_THERMAL_HI];              // [RL2]
    assign thermal_lo_rise_event = rise[SRC_THERMAL_LO];              // [RL3]
    assign enable_rise_event     = enable_rise;                       // [RL4]
    assign enable_fall_event     = enable_fall;                       // [RL5]
    assign gp_pin0_rise_event    = rise[SRC_GP_PIN0] & gp0_counts;    // [RL6]
    assign gp_pin0_fall_event    = fall[SRC_GP_PIN0] & gp0_counts;    // [RL7]
    assign linear_fault_event    = rise[SRC_LINEAR_FAULT];            // [RL8]
    // each high cycle is one event, so a stuck-high timeout re-sets after every read
    assign timeout_event         = armed & BUCK_BOOST_TIMEOUT_IN;     // [RL9]
    assign gp_pin1_rise_event    = rise[SRC_GP_PIN1] & gp1_counts;    // [RL10]
    assign gp_pin1_fall_event    = fall[SRC_GP_PIN1] & gp1_counts;    // [RL11]

    // ************************************************************
    // set vectors
    // ************************************************************
    logic [7:0] set_a;
    logic [7:0] set_b;

    // unused positions stay zero, so nothing can ever set them
    always_comb begin
        set_a                            = 8'h00;
        set_a[DROPOUT_RISE_BIT]          = dropout_rise_event;      // [RL1]
        set_a[THERMAL_ALARM_HI_RISE_BIT] = thermal_hi_rise_event;   // [RL2]
        set_a[THERMAL_ALARM_LO_RISE_BIT] = thermal_lo_rise_event;   // [RL3]
        set_a[ENABLE_PIN_RISE_BIT]       = enable_rise_event;       // [RL4]
        set_a[ENABLE_PIN_FALL_BIT]       = enable_fall_event;       // [RL5]
        set_a[GP_PIN0_RISE_BIT]          = gp_pin0_rise_event;      // [RL6]
        set_a[GP_PIN0_FALL_BIT]          = gp_pin0_fall_event;      // [RL7]
    end

    always_comb begin
        set_b                         = 8'h00;
        set_b[LINEAR_REG_FAULT_BIT]   = linear_fault_event;         // [RL8]
        set_b[BUCK_BOOST_TIMEOUT_BIT] = timeout_event;              // [RL9]
        set_b[GP_PIN1_RISE_BIT]       = gp_pin1_rise_event;         // [RL10]
        set_b[GP_PIN1_FALL_BIT]       = gp_pin1_fall_event;         // [RL11]
    end

    // ************************************************************
    // read decode
    // ************************************************************
    logic read_a;
    logic read_b;

    // an unmapped address matches neither, so it clears nothing
    assign read_a = REG_RD_IN & (REG_ADDR_IN == GLOBAL_EVENT_FLAGS_A_OFFSET);
    assign read_b = REG_RD_IN & (REG_ADDR_IN == GLOBAL_EVENT_FLAGS_B_OFFSET);

    // ************************************************************
    // flag registers
    // ************************************************************
    logic [7:0] global_event_flags_a;
    logic [7:0] global_event_flags_b;
    logic [7:0] kept_a;
    logic [7:0] kept_b;
    logic [7:0] next_global_event_flags_a;
    logic [7:0] next_global_event_flags_b;

    // a read drops everything it returns; a register not read keeps its flags
    assign kept_a = read_a ? 8'h00 : global_event_flags_a;     // [RL13]
    assign kept_b = read_b ? 8'h00 : global_event_flags_b;     // [RL13]
    // set is ored in after the clear so a colliding event survives
    assign next_global_event_flags_a = kept_a | set_a;         // [RL16]
    assign next_global_event_flags_b = kept_b | set_b;         // [RL16]

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            global_event_flags_a <= GLOBAL_EVENT_FLAGS_A_RESET;   // [RL13]
        end else begin
            global_event_flags_a <= next_global_event_flags_a;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            global_event_flags_b <= GLOBAL_EVENT_FLAGS_B_RESET;   // [RL13]
        end else begin
            global_event_flags_b <= next_global_event_flags_b;
        end
    end

    // ************************************************************
    // named flag fields
    // ************************************************************
    logic dropout_rise_flag;
    logic thermal_alarm_hi_rise_flag;
    logic thermal_alarm_lo_rise_flag;
    logic enable_pin_rise_flag;
    logic enable_pin_fall_flag;
    logic gp_pin0_rise_flag;
    logic gp_pin0_fall_flag;
    logic linear_reg_fault_flag;
    logic buck_boost_timeout_flag;
    logic gp_pin1_rise_flag;
    logic gp_pin1_fall_flag;

    assign dropout_rise_flag          = global_event_flags_a[DROPOUT_RISE_BIT];
    assign thermal_alarm_hi_rise_flag = global_event_flags_a[THERMAL_ALARM_HI_RISE_BIT];
    assign thermal_alarm_lo_rise_flag = global_event_flags_a[THERMAL_ALARM_LO_RISE_BIT];
    assign enable_pin_rise_flag       = global_event_flags_a[ENABLE_PIN_RISE_BIT];
    assign enable_pin_fall_flag       = global_event_flags_a[ENABLE_PIN_FALL_BIT];
    assign gp_pin0_rise_flag          = global_event_flags_a[GP_PIN0_RISE_BIT];
    assign gp_pin0_fall_flag          = global_event_flags_a[GP_PIN0_FALL_BIT];
    assign linear_reg_fault_flag      = global_event_flags_b[LINEAR_REG_FAULT_BIT];
    assign buck_boost_timeout_flag    = global_event_flags_b[BUCK_BOOST_TIMEOUT_BIT];
    assign gp_pin1_rise_flag          = global_event_flags_b[GP_PIN1_RISE_BIT];
    assign gp_pin1_fall_flag          = global_event_flags_b[GP_PIN1_FALL_BIT];

    // ************************************************************
    // read words
    // ************************************************************
    logic [7:0] read_word_a;
    logic [7:0] read_word_b;
    logic [7:0] next_rdata;

    // words are rebuilt from the named fields so unused bits read zero by construction
    always_comb begin
        read_word_a                            = 8'h00;                        // [RL12]
        read_word_a[DROPOUT_RISE_BIT]          = dropout_rise_flag;
        read_word_a[THERMAL_ALARM_HI_RISE_BIT] = thermal_alarm_hi_rise_flag;
        read_word_a[THERMAL_ALARM_LO_RISE_BIT] = thermal_alarm_lo_rise_flag;
        read_word_a[ENABLE_PIN_RISE_BIT]       = enable_pin_rise_flag;
        read_word_a[ENABLE_PIN_FALL_BIT]       = enable_pin_fall_flag;
        read_word_a[GP_PIN0_RISE_BIT]          = gp_pin0_rise_flag;
        read_word_a[GP_PIN0_FALL_BIT]          = gp_pin0_fall_flag;
    end

    always_comb begin
        read_word_b                         = 8'h00;                           // [RL12]
        read_word_b[LINEAR_REG_FAULT_BIT]   = linear_reg_fault_flag;
        read_word_b[BUCK_BOOST_TIMEOUT_BIT] = buck_boost_timeout_flag;
        read_word_b[GP_PIN1_RISE_BIT]       = gp_pin1_rise_flag;
        read_word_b[GP_PIN1_FALL_BIT]       = gp_pin1_fall_flag;
    end

    // the word returned is the one before this cycle's clear
    assign next_rdata = read_a ? read_word_a :
                        read_b ? read_word_b : UNMAPPED_READ_VALUE;   // [RL13]

    // ************************************************************
    // read port
    // ************************************************************
    // the answer comes a fixed cycle after the strobe, so the host never polls
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            REG_RVALID_OUT <= 1'b0;
        end else begin
            REG_RVALID_OUT <= REG_RD_IN;
        end
    end

    // data holds between reads so a slow host may pick it up late
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            REG_RDATA_OUT <= READ_DATA_RESET;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= next_rdata;
        end
    end

endmodule

// ### gefr_chk.sv
// checker for the global event flag read port
// assumes it is bound onto the top module's ports
`timescale 1ns/10ps
module gefr_chk (
    // clock and reset
    input wire logic       MCLK_IN,
    input wire logic       NRST_IN,
    // watched inputs
    input wire logic       BUCK_BOOST_TIMEOUT_IN,
    input wire logic       REG_RD_IN,
    input wire logic [7:0] REG_ADDR_IN,
    // watched outputs
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic       REG_RVALID_OUT
);
    logic [2:0] settle;
    wire        rd_a = REG_RD_IN && REG_ADDR_IN == 8'h00;
    wire        rd_b = REG_RD_IN && REG_ADDR_IN == 8'h04;
    wire        rd_x = REG_RD_IN && !rd_a && !rd_b;
    // edge detection is not armed straight after reset
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN)
            settle <= 3'h0;
        else if (settle != 3'h7)
            settle <= settle + 3'h1;
    end
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!NRST_IN);
    AST_RESET_CLEARS: assert property ($rose(NRST_IN) |-> REG_RDATA_OUT == 8'h00 && !REG_RVALID_OUT)
        else $error("read port not clear after reset");
    AST_RVALID_ANSWER: assert property (REG_RD_IN |=> REG_RVALID_OUT)
        else $error("read not answered");
    AST_RVALID_CAUSE: assert property (!REG_RD_IN |=> !REG_RVALID_OUT)
        else $error("valid without read");
    AST_RDATA_HOLD: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
        else $error("read data moved without read");
    AST_UNMAPPED_ZERO: assert property (rd_x |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    AST_RSVD_A: assert property (rd_a |=> !REG_RDATA_OUT[6])
        else $error("unused bit of first register set");
    AST_RSVD_B: assert property (rd_b |=> (REG_RDATA_OUT & 8'hcc) == 8'h00)
        else $error("unused bits of second register set");
    AST_COLLIDE_KEEP: assert property (settle == 3'h7 && rd_b && BUCK_BOOST_TIMEOUT_IN ##2 rd_b |=> REG_RDATA_OUT[4])
        else $error("timeout lost in read clear");
endmodule

// ### gefr_host.sv
// host model: issues reads on the flag registers' read port
// assumes the bench calls rd from its stimulus process
`timescale 1ns/10ps
module gefr_host (
    // clock
    input  wire logic       clk_in,
    // read port
    output logic            rd_out,
    output logic      [7:0] addr_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    initial rd_out = 1'b0;
    initial addr_out = 8'hff;
    // read only, so unused bits are never written with a one
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_in);
        rd_out = 1'b1;
        addr_out = a;
        @(negedge clk_in);
        d = rdata_in;
        v = rvalid_in;
        rd_out = 1'b0;
        // idle address toggles so a stale value cannot pass
        addr_out = ~a;
    endtask
endmodule

// ### global_event_flag_registers_tb_top.sv
// self-checking bench for the global event flag registers
// assumes the host model and checker are compiled first
`timescale 1ns/10ps
module global_event_flag_registers_tb_top;
    logic       clk = 1'b0, nrst = 1'b0, to = 1'b0, d0 = 1'b0, d1 = 1'b0;
    logic [6:0] lv = 7'h10;
    logic       rd, rvalid, gv;
    logic [7:0] addr, rdata, got;
    int         miscompares = 0, n_checks = 0, fa = 0, fb = 0;
    int         rpos[8] = '{7, 5, 4, 5, 3, 1, 1, 4};
    int         fpos[8] = '{-1, -1, -1, -1, 2, 0, 0, -1};
    bit         onb[8] = '{0, 0, 0, 1, 0, 0, 1, 1};
    always #10 clk = ~clk;
    global_event_flag_registers global_event_flag_registers_inst (.MCLK_IN(clk), .NRST_IN(nrst),
        .DROPOUT_DETECT_IN(lv[0]), .THERMAL_THRESHOLD_HI_IN(lv[1]), .THERMAL_THRESHOLD_LO_IN(lv[2]),
        .LINEAR_REG_FAULT_IN(lv[3]), .ENABLE_INPUT_PIN_N_IN(lv[4]), .GP_INPUT0_IN(lv[5]), .GP_INPUT1_IN(lv[6]),
        .GP_PIN0_IS_INPUT_IN(d0), .GP_PIN1_IS_INPUT_IN(d1), .BUCK_BOOST_TIMEOUT_IN(to),
        .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid));
    gefr_host gefr_host_inst (.clk_in(clk), .rd_out(rd), .addr_out(addr), .rdata_in(rdata), .rvalid_in(rvalid));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a);
        int e;
        e = (a == 8'h00) ? fa : (a == 8'h04) ? fb : 0;
        gefr_host_inst.rd(a, got, gv);
        check({7'h00, gv}, 8'h01, "valid");
        check(got, e[7:0], "rdata");
        if (a == 8'h00) fa = 0;
        if (a == 8'h04) fb = 0;
    endtask
    // index 7 is the timeout pulse, the rest toggle one level each
    task automatic fire(input int i);
        int p;
        @(negedge clk);
        if (i == 7) begin
            to = 1'b1;
            @(negedge clk);
            to = 1'b0;
            fb |= 16;
        end else begin
            lv[i] = ~lv[i];
            p = lv[i] ? rpos[i] : fpos[i];
            // output-mode pins must stay silent
            if (p >= 0 && !(i == 5 && !d0) && !(i == 6 && !d1)) begin
                if (onb[i]) fb |= 1 << p;
                else fa |= 1 << p;
            end
        end
        repeat (8) @(negedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(42));
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
        rd_chk(8'h00);
        rd_chk(8'h04);
        repeat (120) begin
            {d1, d0} = 2'($urandom_range(0, 3));
            repeat (4) @(negedge clk);
            fire($urandom_range(0, 7));
            if ($urandom_range(0, 1) == 0) rd_chk(8'($urandom_range(0, 2) * 4));
        end
        rd_chk(8'h04);
        fork
            rd_chk(8'h04);
            begin
                @(negedge clk);
                to = 1'b1;
                @(negedge clk);
                to = 1'b0;
            end
        join
        fb = 16;
        rd_chk(8'h04);
        results();
    end
    initial begin
        #500us;
        miscompares++;
        results();
    end
endmodule
bind global_event_flag_registers gefr_chk gefr_chk_inst (.MCLK_IN, .NRST_IN, .BUCK_BOOST_TIMEOUT_IN,
    .REG_RD_IN, .REG_ADDR_IN, .REG_RDATA_OUT, .REG_RVALID_OUT);
